// File: hw/dcc_consts.vh
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
// Frame layout, MSB first
`define DCC_FRAME_BITS 32
`define DCC_CMD_HI 27
`define DCC_CMD_LO 24
`define DCC_ADR_HI 23
`define DCC_ADR_LO 20
`define DCC_DAT_HI 19
`define DCC_DAT_LO 8
`define DCC_PM_HI 9
`define DCC_PM_LO 8
`define DCC_CH_HI 7
`define DCC_CH_LO 0
// Command codes
`define DCC_CMD_WR_IN 4'h0
`define DCC_CMD_UPD 4'h1
`define DCC_CMD_WR_UPD_ALL 4'h2
`define DCC_CMD_WR_UPD 4'h3
`define DCC_CMD_PWR 4'h4
`define DCC_CMD_CLRC 4'h5
`define DCC_CMD_LDREG 4'h6
`define DCC_CMD_RESET 4'h7
`define DCC_CMD_REF 4'h8
// Address codes
`define DCC_ADR_ALL 4'hf
`define DCC_ADR_MAX 4'h7
// Reset values
`define DCC_REF_RST 1'h0
`define DCC_CLRSEL_RST 2'h0
`define DCC_PM_RST 2'h0
`define DCC_CODE_RST 12'h000
// Power-on guard length in ref_clk cycles
`define DCC_POR_CYCLES 3'h7
// Clear codes
`define DCC_CLR_ZERO 12'h000
`define DCC_CLR_MID 12'h800
`define DCC_CLR_FULL 12'hfff
`define DCC_CLRSEL_NOP 2'h3
`endif

// File: hw/dcc_sync.v
`timescale 1ns/1ns
// Two-flop synchroniser for pins from outside ref_clk domain
module dcc_sync #(
  parameter W = 1
) (
  input wire ref_clk, // Block clock
  input wire rst, // Async reset, active high
  input wire [W-1:0] async_in, // Raw pins
  output reg [W-1:0] sync_out // Synchronised level
);
  reg [W-1:0] meta_ff;

  // First stage feeds only the second
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // dcc_sync

// File: hw/dcc_dac_command_control.v
// Behaviour
// RQ1: Address 0 to 7 picks channel of framed group; 15 picks all eight.
// RQ2: Frame select low over 32 falling clock edges; command runs at 32nd.
// RQ3: Frame select rising early clears shift register and drops the write.
// RQ4: Internal reference enables cleared at power-up.
// RQ5: Command 8 loads frame bit 0 into reference enable.
// RQ6: Outputs held at zero code from power-on until first valid write.
// RQ7: Command 7 restores channel registers and control to reset values.
// RQ8: Load strobe and clear pin ignored while power-on reset is active.
// RQ9: Command 4 takes power mode from frame bits 9 and 8.
// RQ10: Power modes: 0 normal, 1 one kilohm, 2 hundred kilohm, 3 high-Z.
// RQ11: Frame bits 7..0 pick which group channels take the power mode.
// RQ12: With internal reference on, power-down applies to whole group only.
// RQ13: Internal reference is off only when all its group channels are down.
// RQ14: Power-down leaves output registers untouched.
// RQ15: Power-up shows input register if strobe low, else held output value.
// RQ16: Clear pin falling edge loads clear code into all 16 channels.
// RQ17: Command 5 loads clear code select from bits 1..0; default zero code.
// RQ18: Cleared state ends at 32nd falling edge of next complete write.
// RQ19: Clear during a write aborts that write.
// RQ20: Frame: 4 spare, 4 command, 4 address, 12 code, 8 spare, MSB first.
// RQ21: Data sampled on each falling serial clock edge.
// RQ22: Both frame selects low writes both groups at once.
// RQ23: Address 8 to 14 selects no channel.
// RQ24: Clear, power and reference settings held per group.
`timescale 1ns/1ns
`include "dcc_consts.vh"
module dcc_dac_command_control #(
  parameter CH = 8, // Channels per group
  parameter DW = 12 // Code width
) (
  input wire ref_clk, // Block clock, 50 MHz
  input wire rst, // Power-on reset, async, active high
  input wire converter_serial_clock, // Serial clock pin
  input wire converter_serial_input, // Serial data pin
  input wire low_group_frame_select_n, // Frame select, channels 0..7
  input wire high_group_frame_select_n, // Frame select, channels 8..15
  input wire output_load_strobe_n, // Load strobe pin, active low
  input wire output_clear_pin_n, // Clear pin, falling edge active
  output reg [2*CH*DW-1:0] channel_code_ff, // Code presented to each channel
  output reg [4*CH-1:0] power_mode_ff, // Two bits per channel
  output reg [1:0] internal_reference_on_ff, // Reference powered, per group
  output reg [1:0] clear_active_ff // Group in cleared state
);
  localparam NCH = 2 * CH;
  localparam FB = `DCC_FRAME_BITS;

  // Pins pass two flops before use
  // A 160 ns serial clock gives four samples per half period; a slower block clock would miss edges
  wire [4:0] pin_s;
  dcc_sync #(.W(5)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({converter_serial_clock, converter_serial_input, low_group_frame_select_n,
               high_group_frame_select_n, output_clear_pin_n}),
    .sync_out(pin_s)
  );
  wire sclk_s = pin_s[4];
  wire sdin_s = pin_s[3];
  wire fs_lo_n_s = pin_s[2];
  wire fs_hi_n_s = pin_s[1];
  wire clr_n_s = pin_s[0];

  // Strobe level only, so one extra synchroniser
  // Only the level matters for the strobe, so it keeps no edge history
  reg output_load_strobe_meta_ff;
  reg output_load_strobe_s_ff;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      output_load_strobe_meta_ff <= 1'b1;
      output_load_strobe_s_ff <= 1'b1;
    end else begin
      output_load_strobe_meta_ff <= output_load_strobe_n;
      output_load_strobe_s_ff <= output_load_strobe_meta_ff;
    end
  end

  // Edge history for the synchronised pins
  // Reset values match the idle pin levels, so no false edge follows reset
  reg sclk_d_ff;
  reg clr_d_ff;
  reg [1:0] fs_d_ff;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_d_ff <= 1'b1;
      clr_d_ff <= 1'b1;
      fs_d_ff <= 2'h3;
    end else begin
      sclk_d_ff <= sclk_s;
      clr_d_ff <= clr_n_s;
      fs_d_ff <= {fs_hi_n_s, fs_lo_n_s};
    end
  end
  wire sclk_fall = sclk_d_ff & ~sclk_s; // [RQ21]
  wire clr_fall = clr_d_ff & ~clr_n_s;
  wire [1:0] fs_low = ~{fs_hi_n_s, fs_lo_n_s};
  wire [1:0] fs_start = fs_d_ff & fs_low;
  wire any_low = |fs_low;

  // Power-on guard: strobe and clear are ignored for the first cycles after reset
  // Limitation: a clear edge inside the guard is lost, not deferred
  reg [2:0] por_cnt_ff;
  wire por_busy = (por_cnt_ff != `DCC_POR_CYCLES);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      por_cnt_ff <= 3'h0;
    end else if (por_busy) begin
      por_cnt_ff <= por_cnt_ff + 3'h1;
    end
  end
  wire clr_evt = clr_fall & ~por_busy; // [RQ8]
  wire output_load_strobe_low = ~output_load_strobe_s_ff & ~por_busy; // [RQ8]

  // Shift register and bit counter; groups latched at frame start
  // Extra serial clocks after the 32nd are ignored until a select rises and falls again
  reg [FB-1:0] shift_ff;
  reg [5:0] bitcnt_ff;
  reg [1:0] grp_ff;
  reg busy_ff;
  reg [FB-1:0] nxt_shift;
  reg [5:0] nxt_bitcnt;
  reg [1:0] nxt_grp;
  reg nxt_busy;
  reg exec;
  always @* begin
    nxt_shift = shift_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_grp = grp_ff;
    nxt_busy = busy_ff;
    exec = 1'b0;
    if (!any_low || clr_evt) begin
      // Frame cut short or clear hit: discard everything [RQ3] [RQ19]
      nxt_shift = {FB{1'b0}};
      nxt_bitcnt = 6'h0;
      nxt_busy = 1'b0;
      nxt_grp = 2'h0;
    end else if (|fs_start && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_grp = fs_low; // [RQ22]
      nxt_bitcnt = 6'h0;
      nxt_shift = {FB{1'b0}};
    end else if (busy_ff) begin
      // A group whose select rose early drops out of this frame [RQ3]
      nxt_grp = grp_ff & fs_low;
      if (sclk_fall) begin
        nxt_shift = {shift_ff[FB-2:0], sdin_s}; // [RQ20] [RQ21]
        nxt_bitcnt = bitcnt_ff + 6'h1;
        if (bitcnt_ff == FB - 1) begin
          exec = 1'b1; // [RQ2]
          nxt_busy = 1'b0; // Next frame needs a new falling frame select
        end
      end
    end
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= {FB{1'b0}};
      bitcnt_ff <= 6'h0;
      grp_ff <= 2'h0;
      busy_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      bitcnt_ff <= nxt_bitcnt;
      grp_ff <= nxt_grp;
      busy_ff <= nxt_busy;
    end
  end

  // Decode the completed frame
  // Decoding nxt_shift lets the command act in the same cycle as the 32nd bit
  // Fields outside a command's own layout are don't care and go unused
  wire [3:0] cmd = nxt_shift[`DCC_CMD_HI:`DCC_CMD_LO];
  wire [3:0] adr = nxt_shift[`DCC_ADR_HI:`DCC_ADR_LO];
  wire [DW-1:0] dat = nxt_shift[`DCC_DAT_HI:`DCC_DAT_LO];
  wire [1:0] pm = nxt_shift[`DCC_PM_HI:`DCC_PM_LO];
  wire [CH-1:0] pm_sel = nxt_shift[`DCC_CH_HI:`DCC_CH_LO];
  wire [CH-1:0] ldreg_bits = nxt_shift[`DCC_CH_HI:`DCC_CH_LO];
  wire [1:0] clrsel_bits = nxt_shift[1:0];
  wire ref_bit = nxt_shift[0];

  // Per-group settings [RQ24]
  reg [1:0] ref_en_ff; // internal_reference_enable
  reg [3:0] clrsel_ff; // clear_code_select, two per group
  reg [2*CH-1:0] ldreg_ff; // Per-channel strobe override
  reg [1:0] first_ok_ff; // A valid write has completed since reset
  reg [NCH*DW-1:0] in_reg_ff;
  reg [NCH*DW-1:0] out_reg_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : grp_ctl
      wire hit = exec && nxt_grp[g];
      wire soft_rst = hit && (cmd == `DCC_CMD_RESET); // [RQ7]
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ref_en_ff[g] <= `DCC_REF_RST; // [RQ4]
          clrsel_ff[2*g+1:2*g] <= `DCC_CLRSEL_RST; // [RQ17]
          ldreg_ff[CH*g+CH-1:CH*g] <= {CH{1'b0}};
          first_ok_ff[g] <= 1'b0;
          clear_active_ff[g] <= 1'b0;
        end else begin
          // Clear wins over a write in the same cycle; that write is aborted anyway
          if (clr_evt) begin
            clear_active_ff[g] <= 1'b1;
          end else if (hit) begin
            clear_active_ff[g] <= 1'b0; // [RQ18]
          end
          if (soft_rst) begin
            ref_en_ff[g] <= `DCC_REF_RST;
            clrsel_ff[2*g+1:2*g] <= `DCC_CLRSEL_RST;
            ldreg_ff[CH*g+CH-1:CH*g] <= {CH{1'b0}};
            first_ok_ff[g] <= 1'b0; // Back to zero-code hold
          end else if (hit) begin
            first_ok_ff[g] <= 1'b1; // [RQ6]
            if (cmd == `DCC_CMD_REF) begin
              ref_en_ff[g] <= ref_bit; // [RQ5]
            end
            if (cmd == `DCC_CMD_CLRC) begin
              clrsel_ff[2*g+1:2*g] <= clrsel_bits; // [RQ17]
            end
            if (cmd == `DCC_CMD_LDREG) begin
              ldreg_ff[CH*g+CH-1:CH*g] <= ldreg_bits;
            end
          end
        end
      end
    end
  endgenerate

  // Clear code decode per group; select 3 is no operation
  // Select 3 never reaches this function; the default only keeps the case complete
  function [DW-1:0] clr_code;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: clr_code = `DCC_CLR_ZERO;
        2'h1: clr_code = `DCC_CLR_MID;
        2'h2: clr_code = `DCC_CLR_FULL;
        default: clr_code = `DCC_CLR_ZERO;
      endcase
    end
  endfunction

  // Group power-mode gate: a subset request is dropped while reference is on
  // Dropping the whole request keeps the group from splitting while the reference runs
  wire [1:0] pm_cmd_ok;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pm_gate
      assign pm_cmd_ok[g] = exec && nxt_grp[g] && (cmd == `DCC_CMD_PWR) &&
                            (!ref_en_ff[g] || pm_sel == {CH{1'b1}}); // [RQ12]
    end
  endgenerate

  // Per-channel registers
  // Priority: soft reset, then clear, then the frame's own command
  // Strobe held low tracks the input register for every powered channel
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : chan
      localparam G = c / CH;
      localparam L = c % CH;
      wire hit = exec && nxt_grp[G];
      wire sel = hit && ((adr == `DCC_ADR_ALL) || (adr <= `DCC_ADR_MAX && adr[2:0] == L)); // [RQ1] [RQ23]
      wire sync_upd = ldreg_ff[c] || output_load_strobe_low;
      wire [1:0] clrsel = clrsel_ff[2*G+1:2*G];
      wire [DW-1:0] in_now = in_reg_ff[c*DW+DW-1:c*DW];
      wire [1:0] pm_now = power_mode_ff[2*c+1:2*c];
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          in_reg_ff[c*DW+DW-1:c*DW] <= `DCC_CODE_RST;
          out_reg_ff[c*DW+DW-1:c*DW] <= `DCC_CODE_RST;
          power_mode_ff[2*c+1:2*c] <= `DCC_PM_RST;
        end else if (hit && cmd == `DCC_CMD_RESET) begin
          in_reg_ff[c*DW+DW-1:c*DW] <= `DCC_CODE_RST; // [RQ7]
          out_reg_ff[c*DW+DW-1:c*DW] <= `DCC_CODE_RST;
          power_mode_ff[2*c+1:2*c] <= `DCC_PM_RST;
        end else if (clr_evt && clrsel != `DCC_CLRSEL_NOP) begin
          in_reg_ff[c*DW+DW-1:c*DW] <= clr_code(clrsel); // [RQ16]
          out_reg_ff[c*DW+DW-1:c*DW] <= clr_code(clrsel);
        end else begin
          if (pm_cmd_ok[G] && pm_sel[L]) begin
            power_mode_ff[2*c+1:2*c] <= pm; // [RQ9] [RQ10] [RQ11]
            // Power-up with strobe low shows the input register [RQ15]
            if (pm == `DCC_PM_RST && pm_now != `DCC_PM_RST && output_load_strobe_low) begin
              out_reg_ff[c*DW+DW-1:c*DW] <= in_now;
            end
          end
          if (sel && (cmd == `DCC_CMD_WR_IN || cmd == `DCC_CMD_WR_UPD_ALL || cmd == `DCC_CMD_WR_UPD)) begin
            in_reg_ff[c*DW+DW-1:c*DW] <= dat;
          end
          // Output register updates; power-down never touches it, power-up with strobe low loads the input register [RQ14]
          if (sel && cmd == `DCC_CMD_WR_UPD) begin
            out_reg_ff[c*DW+DW-1:c*DW] <= dat;
          end else if (sel && cmd == `DCC_CMD_WR_IN && sync_upd) begin
            out_reg_ff[c*DW+DW-1:c*DW] <= dat;
          end else if (sel && cmd == `DCC_CMD_WR_UPD_ALL) begin
            out_reg_ff[c*DW+DW-1:c*DW] <= dat;
          end else if (hit && cmd == `DCC_CMD_WR_UPD_ALL) begin
            out_reg_ff[c*DW+DW-1:c*DW] <= in_now;
          end else if (sel && cmd == `DCC_CMD_UPD) begin
            out_reg_ff[c*DW+DW-1:c*DW] <= in_now;
          end else if (~output_load_strobe_s_ff && output_load_strobe_low && pm_now == `DCC_PM_RST) begin
            out_reg_ff[c*DW+DW-1:c*DW] <= in_now; // Asynchronous strobe load
          end
        end
      end

      // Zero code until first valid write of this group [RQ6]
      // Registered so the pins see one clean change per update
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          channel_code_ff[c*DW+DW-1:c*DW] <= `DCC_CODE_RST;
        end else if (!first_ok_ff[G]) begin
          channel_code_ff[c*DW+DW-1:c*DW] <= `DCC_CODE_RST;
        end else begin
          channel_code_ff[c*DW+DW-1:c*DW] <= out_reg_ff[c*DW+DW-1:c*DW];
        end
      end
    end
  endgenerate

  // Reference runs while enabled and any channel of the group is up [RQ13]
  // One cycle behind the power modes; the analog side settles far slower
  generate
    for (g = 0; g < 2; g = g + 1) begin : ref_pwr
      wire [CH-1:0] up;
      genvar k;
      for (k = 0; k < CH; k = k + 1) begin : up_bit
        assign up[k] = (power_mode_ff[2*(g*CH+k)+1:2*(g*CH+k)] == `DCC_PM_RST);
      end
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          internal_reference_on_ff[g] <= 1'b0;
        end else begin
          internal_reference_on_ff[g] <= ref_en_ff[g] && (|up);
        end
      end
    end
  endgenerate
endmodule // dcc_dac_command_control

// File: tb/dcc_props.sv
`timescale 1ns/1ns
// Pin checks; ages count cycles since the 32nd serial fall and since a clear fall
module dcc_props #(
  parameter CH = 8, // Channels per group
  parameter DW = 12 // Code width
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic converter_serial_clock, // Serial clock
  input wire logic low_group_frame_select_n, // Low frame select
  input wire logic high_group_frame_select_n, // High frame select
  input wire logic output_clear_pin_n, // Clear pin
  input wire logic [2*CH*DW-1:0] channel_code_ff, // Codes
  input wire logic [4*CH-1:0] power_mode_ff, // Power modes
  input wire logic [1:0] internal_reference_on_ff, // Reference
  input wire logic [1:0] clear_active_ff // Cleared state
);
  logic sclk_ff, clr_ff, all_dn;
  logic [5:0] cnt_ff, age_ff, agec_ff, idle_ff, since_ff;
  wire frm = !(low_group_frame_select_n && high_group_frame_select_n);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Saturating counters, except cnt_ff which clears between frames; every bound below is under 64
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_ff <= 1'b1;
      clr_ff <= 1'b1;
      cnt_ff <= 6'h00;
      age_ff <= 6'h3f;
      agec_ff <= 6'h3f;
      idle_ff <= 6'h00;
      since_ff <= 6'h00;
    end else begin
      sclk_ff <= converter_serial_clock;
      clr_ff <= output_clear_pin_n;
      cnt_ff <= !frm ? 6'h00 : cnt_ff + {5'h00, sclk_ff & ~converter_serial_clock};
      age_ff <= (frm && cnt_ff == 6'h20) ? 6'h00 : age_ff + {5'h00, age_ff != 6'h3f};
      agec_ff <= (clr_ff && !output_clear_pin_n) ? 6'h00 : agec_ff + {5'h00, agec_ff != 6'h3f};
      idle_ff <= (frm || !output_clear_pin_n) ? 6'h00 : idle_ff + {5'h00, idle_ff != 6'h3f};
      since_ff <= since_ff + {5'h00, since_ff != 6'h3f};
    end
  end
  // Low group fully powered down
  always @* begin
    all_dn = 1'b1;
    for (int c = 0; c < CH; c++) begin
      if (power_mode_ff[2*c +: 2] == 2'h0) all_dn = 1'b0;
    end
  end
  property p_rst_zero; $fell(rst) |-> !(|{channel_code_ff, power_mode_ff, internal_reference_on_ff, clear_active_ff}); endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not zero after reset");
  property p_idle; idle_ff > 6'h0c |-> $stable(power_mode_ff) && $stable(internal_reference_on_ff) && $stable(clear_active_ff); endproperty
  a_idle: assert property (p_idle) else $error("state changed with no frame or clear");
  property p_after_32; !$stable(power_mode_ff) || !$stable(internal_reference_on_ff) |-> age_ff < 6'h0d; endproperty
  a_after_32: assert property (p_after_32) else $error("mode changed without a full frame");
  property p_clr_set; $fell(output_clear_pin_n) && since_ff > 6'h0c |-> ##[2:10] clear_active_ff == 2'h3; endproperty
  a_clr_set: assert property (p_clr_set) else $error("clear edge not taken");
  property p_clr_cause; $rose(clear_active_ff[1]) |-> agec_ff < 6'h0b; endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("cleared state with no clear edge");
  property p_guard; $fell(output_clear_pin_n) && since_ff < 6'h02 |-> (clear_active_ff == 2'h0) [*8]; endproperty
  a_guard: assert property (p_guard) else $error("clear acted during power-on guard");
  property p_clr_exit; $fell(clear_active_ff[0]) |-> age_ff < 6'h0d; endproperty
  a_clr_exit: assert property (p_clr_exit) else $error("cleared state left without a frame");
  property p_ref_off; all_dn [*3] |-> !internal_reference_on_ff[0]; endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference on with group down");
endmodule // dcc_props

bind dcc_dac_command_control dcc_props #(.CH(CH), .DW(DW)) dcc_props_i (.ref_clk(ref_clk), .rst(rst),
  .converter_serial_clock(converter_serial_clock), .low_group_frame_select_n(low_group_frame_select_n),
  .high_group_frame_select_n(high_group_frame_select_n), .output_clear_pin_n(output_clear_pin_n),
  .channel_code_ff(channel_code_ff), .power_mode_ff(power_mode_ff),
  .internal_reference_on_ff(internal_reference_on_ff), .clear_active_ff(clear_active_ff));

// File: tb/dcc_host.sv
`timescale 1ns/1ns
// Host end of the serial link; clock idles high between frames
module dcc_host (
  input wire logic ref_clk, // Bench clock
  output logic sclk, // Serial clock
  output logic sdin, // Serial data
  output logic [1:0] sel_n // Frame selects, bit 0 low group
);
  logic busy = 1'b0, d_bit = 1'b0, tgl = 1'b0;
  initial sclk = 1'b1;
  initial sel_n = 2'h3;
  // Released data toggles so a stale bit never passes for data
  always @(negedge ref_clk) tgl <= ~tgl;
  assign sdin = busy ? d_bit : tgl;
  // A count under 32 cuts the frame short
  task automatic send(input logic [1:0] grp, input logic [31:0] w, input int nbits);
    busy = 1'b1;
    repeat (4) @(negedge ref_clk);
    sel_n = ~grp;
    for (int i = 31; i > 31 - nbits; i--) begin
      d_bit = w[i];
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
    end
    repeat (4) @(negedge ref_clk);
    sel_n = 2'h3;
    busy = 1'b0;
    repeat (12) @(negedge ref_clk);
  endtask
endmodule // dcc_host

// File: tb/test_dac_command_control.sv
`timescale 1ns/1ns
module test_dac_command_control;
  logic ref_clk = 1'b0, rst = 1'b1, clr_n = 1'b1, ld_n = 1'b1, sclk, sdin;
  logic [1:0] sel_n, ref_on, clr_on;
  logic [191:0] codes;
  logic [31:0] pmode;
  int num_errors = 0, n_checks = 0;
  int code[16], inr[16], pm[16], ref_en[2], clrsel[2], clr_act[2];
  always #10 ref_clk = ~ref_clk;
  dcc_host dcc_host_i (.ref_clk(ref_clk), .sclk(sclk), .sdin(sdin), .sel_n(sel_n));
  dcc_dac_command_control #(.CH(8), .DW(12)) dcc_dac_command_control_i (.ref_clk(ref_clk), .rst(rst),
    .converter_serial_clock(sclk), .converter_serial_input(sdin), .low_group_frame_select_n(sel_n[0]),
    .high_group_frame_select_n(sel_n[1]), .output_load_strobe_n(ld_n), .output_clear_pin_n(clr_n),
    .channel_code_ff(codes), .power_mode_ff(pmode), .internal_reference_on_ff(ref_on), .clear_active_ff(clr_on));
  // Frame word; spare nibble is noise
  function automatic logic [31:0] fw(input logic [3:0] cmd, input logic [3:0] adr, input logic [11:0] d,
    input logic [7:0] lo);
    fw = {4'($urandom), cmd, adr, d, lo};
  endfunction
  // Reference model of one executed frame
  task automatic apply(input logic [1:0] grp, input logic [31:0] w);
    for (int c = 0; c < 16; c++) if (!ld_n && pm[c] == 0) code[c] = inr[c];
    for (int g = 0; g < 2; g++) if (grp[g]) begin
      clr_act[g] = 0;
      for (int c = 0; c < 8; c++) begin
        if (w[23:20] == c || w[23:20] == 4'hf) begin
          if (w[27:24] == 4'h3 || w[27:24] == 4'h0) inr[8*g+c] = w[19:8];
          if (w[27:24] == 4'h3 || (w[27:24] == 4'h0 && !ld_n)) code[8*g+c] = w[19:8];
        end
        if (w[27:24] == 4'h4 && w[c] && (ref_en[g] == 0 || w[7:0] == 8'hff)) begin
          if (w[9:8] == 2'h0 && pm[8*g+c] != 0 && !ld_n) code[8*g+c] = inr[8*g+c];
          pm[8*g+c] = w[9:8];
        end
        if (w[27:24] == 4'h7) code[8*g+c] = 0;
        if (w[27:24] == 4'h7) inr[8*g+c] = 0;
        if (w[27:24] == 4'h7) pm[8*g+c] = 0;
      end
      if (w[27:24] == 4'h5) clrsel[g] = w[1:0];
      if (w[27:24] == 4'h7) clrsel[g] = 0;
      if (w[27:24] == 4'h8 || w[27:24] == 4'h7) ref_en[g] = w[27:24] == 4'h8 ? w[0] : 0;
    end
    for (int c = 0; c < 16; c++) if (!ld_n && pm[c] == 0) code[c] = inr[c];
  endtask
  task automatic check_all(input string what);
    logic [191:0] ec;
    logic [31:0] ep;
    logic [1:0] er, ea;
    for (int c = 0; c < 16; c++) begin
      ec[12*c +: 12] = 12'(code[c]);
      ep[2*c +: 2] = 2'(pm[c]);
    end
    for (int g = 0; g < 2; g++) begin
      er[g] = 1'b0;
      ea[g] = 1'(clr_act[g]);
      for (int c = 8*g; c < 8*g+8; c++) if (pm[c] == 0) er[g] = 1'(ref_en[g]);
    end
    n_checks++;
    if ({codes, pmode, ref_on, clr_on} !== {ec, ep, er, ea}) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
    $display("Test ended: %s", what);
  endtask
  task automatic wr(input logic [1:0] grp, input logic [31:0] w);
    wrl(grp, w, 1'($urandom));
  endtask
  // Write with a chosen strobe level, held through the frame
  task automatic wrl(input logic [1:0] grp, input logic [31:0] w, input logic ld);
    ld_n = ld;
    dcc_host_i.send(grp, w, 32);
    apply(grp, w);
  endtask
  // Clear pulse; model loads each group's own clear code
  task automatic pulse_clr(input bit upd);
    @(negedge ref_clk);
    clr_n = 1'b0;
    for (int c = 0; c < 16; c++) if (upd && clrsel[c/8] != 3) begin
      code[c] = clrsel[c/8] == 0 ? 0 : clrsel[c/8] == 1 ? 12'h800 : 12'hfff;
      inr[c] = code[c];
    end
    if (upd) clr_act = '{1, 1};
    repeat (4) @(negedge ref_clk);
    clr_n = 1'b1;
    repeat (12) @(negedge ref_clk);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    finish_test();
  end
  initial begin
    void'($urandom(39));
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    pulse_clr(1'b0);
    check_all("power-on state");
    for (int a = 0; a < 16; a++) begin
      wr(2'(a % 3 + 1), fw(4'h3, 4'(a), 12'($urandom), 8'h00));
      check_all("address decode");
    end
    dcc_host_i.send(2'h3, fw(4'h3, 4'hf, 12'hfff, 8'h00), int'(1 + $urandom % 31));
    check_all("cut-short frame");
    pulse_clr(1'b1);
    check_all("default clear");
    for (int s = 0; s < 4; s++) begin
      wr(2'h3, fw(4'h3, 4'hf, 12'($urandom), 8'h00));
      wr(2'h1, fw(4'h5, 4'h0, 12'h000, 8'(s)));
      wr(2'h2, fw(4'h5, 4'h0, 12'h000, 8'(3 - s)));
      pulse_clr(1'b1);
      check_all("clear code");
    end
    wr(2'h2, fw(4'h3, 4'h2, 12'h5a5, 8'h00));
    check_all("leave clear");
    fork
      dcc_host_i.send(2'h1, fw(4'h3, 4'hf, 12'h123, 8'h00), 32);
      begin
        repeat (100) @(negedge ref_clk);
        pulse_clr(1'b1);
      end
    join
    check_all("clear in frame");
    for (int m = 0; m < 4; m++) begin
      wr(2'h1, fw(4'h4, 4'h0, 12'(m), 8'($urandom)));
      check_all("power mode");
    end
    wr(2'h3, fw(4'h8, 4'h0, 12'h000, 8'h01));
    check_all("reference on");
    wr(2'h1, fw(4'h4, 4'h0, 12'h002, 8'h0f));
    check_all("subset refused");
    for (int l = 1; l >= 0; l--) begin
      wrl(2'h1, fw(4'h4, 4'h0, 12'h003, 8'hff), 1'b1);
      check_all("group down");
      wrl(2'h1, fw(4'h0, 4'hf, 12'($urandom), 8'h00), 1'b1);
      check_all("input only while down");
      wrl(2'h1, fw(4'h4, 4'h0, 12'h000, 8'hff), 1'(l));
      check_all("power up");
    end
    wr(2'h2, fw(4'h8, 4'h0, 12'h000, 8'h00));
    check_all("reference off");
    wr(2'h1, fw(4'h7, 4'h0, 12'h000, 8'h00));
    check_all("soft reset");
    finish_test();
  end
endmodule // test_dac_command_control
